// File: shared/store_program_control_map.vh
// Purpose: constants for the self-programming control logic
// Assumes: included by bare name
// Notes:   control register bit positions, commands and timing
`ifndef STORE_PROGRAM_CONTROL_MAP_VH
`define STORE_PROGRAM_CONTROL_MAP_VH
`define SPC_REG_OFFSET      4'h0
`define SPC_LOCK_OFFSET     4'h1
`define SPC_FUSE_OFFSET     4'h2
`define SPC_RESET_VALUE     8'h00
`define SPC_BIT_IRQ_EN      7
`define SPC_BIT_BUSY        6
`define SPC_BIT_REENABLE    4
`define SPC_BIT_LOCK_SET    3
`define SPC_BIT_PAGE_WRITE  2
`define SPC_BIT_PAGE_ERASE  1
`define SPC_BIT_STORE_EN    0
`define SPC_CMD_REENABLE    5'h11
`define SPC_CMD_LOCK_SET    5'h09
`define SPC_CMD_PAGE_WRITE  5'h05
`define SPC_CMD_PAGE_ERASE  5'h03
`define SPC_CMD_LOAD        5'h01
`define SPC_ARM_CYCLES      3'h4
`define SPC_LOAD_CYCLES     3'h3
`define SPC_APP_VECTOR      16'h0000
`define SPC_OP_CYCLES       16'h0020
`endif

// File: core/page_buffer.v
// Purpose: temporary page buffer, one word per entry
// Assumes: words written once between clears
// Notes:   clear empties every entry in one cycle
`timescale 1ns/1ps
`default_nettype none
module page_buffer #(
    parameter WORD_BITS = 6
) (
    input  wire                 clk,      // Core clock
    input  wire                 sys_rst,  // Synchronous reset
    input  wire                 clear,    // Empty the buffer
    input  wire                 wr_en,    // Store one word
    input  wire [WORD_BITS-1:0] wr_addr,  // Word index
    input  wire [15:0]          wr_data,  // Word data
    input  wire [WORD_BITS-1:0] rd_addr,  // Read index
    output wire [15:0]          rd_data,  // Read data
    output wire                 any_valid // Some word loaded
);
    localparam DEPTH = 1 << WORD_BITS;
    reg [15:0]      mem_reg [0:DEPTH-1];
    reg [DEPTH-1:0] valid_reg;
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1)
        begin : g_ent
            always @(posedge clk)
            begin
                if (sys_rst || clear)
                begin
                    mem_reg[i]   <= 16'hFFFF;
                    valid_reg[i] <= 1'b0;
                end
                else if (wr_en && wr_addr == i)
                begin
                    mem_reg[i]   <= wr_data;
                    valid_reg[i] <= 1'b1;
                end
            end
        end
    endgenerate
    assign rd_data   = mem_reg[rd_addr];
    assign any_valid = |valid_reg;
endmodule
`default_nettype wire

// File: core/flash_self_program_control.v
// Purpose: control register and sequencer for flash self-programming
// Assumes: core gives one-cycle store/load strobes; flash_done ends an operation
// Notes on behaviour
// - Reset vector is 0 when boot fuse is 1, else boot loader start; here 0 during reset and one cycle after, whatever the fuse.
// - Ready interrupt requested while enabled, global flag set, store enable clear.
// - Busy flag set when erase or write to concurrent section starts.
// - Busy flag clears on re-enable after programming, or on page load.
// - Bit 5 of control register reads zero.
// - Re-enable armed with store enable unblocks section on store within four cycles.
// - Re-enable refused while erase or write is in progress.
// - Re-enable during loading aborts load and discards buffer.
// - Lock-set store programs lock bits from low data only.
// - Lock-set bit clears on completion or after four idle cycles.
// - Load within three cycles of lock-set returns lock or fuse by bit zero.
// - Page-write store writes buffer to page from upper pointer bits.
// - Page-write bit clears when write ends or after four idle cycles.
// - Core stalled during page write to stalling section.
// - Page-erase store erases page from upper pointer bits.
// - Page-erase bit clears when erase ends or after four idle cycles.
// - Store enable alone arms page-buffer word load from data registers.
// - Store enable clears after store or four cycles; held during operations.
// - Only five command patterns in low bits have effect.
// - Pointer low bits select word, high bits select page.
// - Target address latched when an operation starts.
// - Program loads address bytes, pointer bit zero picks the byte.
// - Page buffer clears after page write, re-enable and reset.
// - Erase to stalling section stalls core; other erase blocks the concurrent section.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "store_program_control_map.vh"
module flash_self_program_control #(
    parameter WORD_BITS  = 6,                   // Word index width
    parameter PAGE_BITS  = 7,                   // Page index width
    parameter STALL_PAGE = 7'h70,               // First page of stalling section
    parameter BOOT_VECTOR = 16'h1C00            // Boot loader start, plain default
) (
    input  wire        clk,           // Core clock, 10 MHz
    input  wire        sys_rst,       // Synchronous reset, high
    input  wire [3:0]  reg_addr,      // Register address
    input  wire [7:0]  reg_wdata,     // Write data
    input  wire        reg_wr,        // Write strobe
    input  wire        reg_rd,        // Read strobe
    output reg  [7:0]  reg_rdata,     // Read data, cycle after strobe
    input  wire        boot_vector_fuse, // 1 unprogrammed, 0 programmed
    input  wire        global_irq_en, // Core global interrupt flag
    input  wire        store_program_instr, // Store instruction strobe
    input  wire        load_program_instr,  // Load instruction strobe
    input  wire [15:0] pointer,       // Address pointer
    input  wire [15:0] data_regs,     // High:low data registers
    input  wire [7:0]  lock_bits_in,  // Current lock bits
    input  wire [7:0]  fuse_bits_in,  // Current fuse bits
    input  wire [7:0]  flash_byte,    // Flash byte at load address
    input  wire        flash_done,    // Array operation finished
    output reg  [15:0] reset_vector,  // Reset vector
    output reg         irq_req,       // Store-ready interrupt request
    output reg         stall_core,    // Halt core during operation on stalling section
    output reg         section_blocked, // Concurrent section unreadable
    output reg  [7:0]  load_data,     // Load instruction result
    output reg         load_valid,    // Load result strobe
    output reg         erase_start,   // Page erase start pulse
    output reg         write_start,   // Page write start pulse
    output reg  [PAGE_BITS-1:0] op_page, // Latched target page
    output reg         lock_prog,     // Lock programming pulse
    output reg  [7:0]  lock_data,     // Lock value to program
    output reg  [15:0] write_word,    // Buffer word toward array
    output reg  [WORD_BITS-1:0] word_addr // Buffer index toward array
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_ARMED = 2'h1;
    localparam ST_BUSY  = 2'h2;

    reg [1:0]  state_reg;
    reg [4:0]  cmd_reg;
    reg        irq_en_reg;
    reg        busy_reg;
    reg [2:0]  win_reg;
    reg        loading_reg;
    reg        write_op_reg;
    reg [WORD_BITS-1:0] rd_idx_reg;

    wire [WORD_BITS-1:0] word_field = pointer[WORD_BITS:1];
    wire [PAGE_BITS-1:0] page_field = pointer[WORD_BITS+PAGE_BITS:WORD_BITS+1];
    wire [4:0] wcmd = reg_wdata[4:0];
    wire ctrl_wr = reg_wr && reg_addr == `SPC_REG_OFFSET;
    // Five legal patterns only
    wire cmd_ok = (wcmd == `SPC_CMD_REENABLE) || (wcmd == `SPC_CMD_LOCK_SET) ||
                  (wcmd == `SPC_CMD_PAGE_WRITE) || (wcmd == `SPC_CMD_PAGE_ERASE) ||
                  (wcmd == `SPC_CMD_LOAD);
    wire armed   = state_reg == ST_ARMED;
    wire do_store = armed && store_program_instr;
    wire buf_load = do_store && cmd_reg == `SPC_CMD_LOAD;
    wire buf_clear = (do_store && cmd_reg == `SPC_CMD_REENABLE) ||
                     (state_reg == ST_BUSY && flash_done && write_op_reg) ||
                     (ctrl_wr && wcmd == `SPC_CMD_REENABLE && loading_reg &&
                      state_reg != ST_BUSY);
    wire [15:0] buf_rdata;

    page_buffer #(.WORD_BITS(WORD_BITS)) u_buf (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clear     (buf_clear),
        .wr_en     (buf_load),
        .wr_addr   (word_field),
        .wr_data   (data_regs),
        .rd_addr   (rd_idx_reg),
        .rd_data   (buf_rdata),
        .any_valid ()
    );

    wire [7:0] ctrl_value = {irq_en_reg, busy_reg, 1'b0, cmd_reg};
    wire       store_en   = cmd_reg[`SPC_BIT_STORE_EN];

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg    <= ST_IDLE;
            cmd_reg      <= 5'h00;
            irq_en_reg   <= 1'b0;
            busy_reg     <= 1'b0;
            win_reg      <= 3'h0;
            loading_reg  <= 1'b0;
            write_op_reg <= 1'b0;
            rd_idx_reg   <= {WORD_BITS{1'b0}};
            reg_rdata    <= 8'h00;
            reset_vector <= `SPC_APP_VECTOR;
            irq_req      <= 1'b0;
            stall_core   <= 1'b0;
            section_blocked <= 1'b0;
            load_data    <= 8'h00;
            load_valid   <= 1'b0;
            erase_start  <= 1'b0;
            write_start  <= 1'b0;
            op_page      <= {PAGE_BITS{1'b0}};
            lock_prog    <= 1'b0;
            lock_data    <= 8'h00;
            write_word   <= 16'h0000;
            word_addr    <= {WORD_BITS{1'b0}};
        end
        else
        begin
            erase_start <= 1'b0;
            write_start <= 1'b0;
            lock_prog   <= 1'b0;
            load_valid  <= 1'b0;
            reset_vector <= boot_vector_fuse ? `SPC_APP_VECTOR : BOOT_VECTOR;
            if (ctrl_wr)
                irq_en_reg <= reg_wdata[`SPC_BIT_IRQ_EN];
            case (state_reg)
                ST_IDLE:
                begin
                    if (ctrl_wr && cmd_ok)
                    begin
                        cmd_reg   <= wcmd;
                        win_reg   <= `SPC_ARM_CYCLES;
                        state_reg <= ST_ARMED;
                        if (wcmd == `SPC_CMD_REENABLE)
                            loading_reg <= 1'b0;
                    end
                end
                ST_ARMED:
                begin
                    if (do_store)
                    begin
                        op_page <= page_field;
                        case (cmd_reg)
                            `SPC_CMD_PAGE_ERASE, `SPC_CMD_PAGE_WRITE:
                            begin
                                erase_start  <= cmd_reg == `SPC_CMD_PAGE_ERASE;
                                write_start  <= cmd_reg == `SPC_CMD_PAGE_WRITE;
                                write_op_reg <= cmd_reg == `SPC_CMD_PAGE_WRITE;
                                rd_idx_reg   <= {WORD_BITS{1'b0}};
                                stall_core   <= page_field >= STALL_PAGE;
                                if (page_field < STALL_PAGE)
                                    busy_reg <= 1'b1;
                                state_reg <= ST_BUSY;
                            end
                            `SPC_CMD_LOCK_SET:
                            begin
                                lock_prog <= 1'b1;
                                lock_data <= data_regs[7:0];
                                cmd_reg   <= 5'h00;
                                state_reg <= ST_IDLE;
                            end
                            `SPC_CMD_REENABLE:
                            begin
                                busy_reg  <= 1'b0;
                                cmd_reg   <= 5'h00;
                                state_reg <= ST_IDLE;
                            end
                            default:
                            begin
                                busy_reg    <= 1'b0;
                                loading_reg <= 1'b1;
                                cmd_reg     <= 5'h00;
                                state_reg   <= ST_IDLE;
                            end
                        endcase
                    end
                    else if (win_reg == 3'h1)
                    begin
                        cmd_reg   <= 5'h00;
                        state_reg <= ST_IDLE;
                    end
                    if (!do_store)
                        win_reg <= win_reg - 3'h1;
                end
                ST_BUSY:
                begin
                    // Stream buffer words toward array during a write
                    if (write_op_reg)
                    begin
                        word_addr  <= rd_idx_reg;
                        write_word <= buf_rdata;
                        rd_idx_reg <= rd_idx_reg + {{(WORD_BITS-1){1'b0}}, 1'b1};
                    end
                    if (flash_done)
                    begin
                        cmd_reg      <= 5'h00;
                        stall_core   <= 1'b0;
                        write_op_reg <= 1'b0;
                        if (write_op_reg)
                            loading_reg <= 1'b0;
                        state_reg    <= ST_IDLE;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
            // Load returns lock or fuse in early window
            // Byte addressed by pointer bit zero
            if (load_program_instr)
            begin
                load_valid <= 1'b1;
                if (armed && cmd_reg == `SPC_CMD_LOCK_SET &&
                    win_reg > (`SPC_ARM_CYCLES - `SPC_LOAD_CYCLES))
                    load_data <= pointer[0] ? fuse_bits_in : lock_bits_in;
                else
                    load_data <= flash_byte;
            end
            if (reg_rd)
            begin
                case (reg_addr)
                    `SPC_REG_OFFSET:  reg_rdata <= ctrl_value;
                    `SPC_LOCK_OFFSET: reg_rdata <= lock_bits_in;
                    `SPC_FUSE_OFFSET: reg_rdata <= fuse_bits_in;
                    default:          reg_rdata <= 8'h00;
                endcase
            end
            else
                reg_rdata <= 8'h00;
            // Level request while store enable clear
            irq_req <= irq_en_reg && global_irq_en && !store_en;
            section_blocked <= busy_reg;
        end
    end
endmodule
`default_nettype wire

// File: dv/flash_array_model.sv
// Purpose: flash array stand-in that finishes erase and write
// Assumes: one start at a time
// Notes:   DELAY is far shorter than a real array
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
    parameter int DELAY = 20
) (
    input  wire logic clk,         // Core clock
    input  wire logic sys_rst,     // Synchronous reset
    input  wire logic erase_start, // Erase begins
    input  wire logic write_start, // Write begins
    output wire logic flash_done   // One-cycle finish pulse
);
    int cnt_reg = 0;
    assign flash_done = (cnt_reg == 1);
    always @(posedge clk)
    begin
        if (sys_rst)
            cnt_reg <= 0;
        else if (erase_start || write_start)
            cnt_reg <= DELAY;
        else if (cnt_reg != 0)
            cnt_reg <= cnt_reg - 1;
    end
endmodule
`default_nettype wire

// File: dv/fspc_monitor.sv
// Purpose: port checker for the self-programming control
// Assumes: bound to the design top
// Notes:   start pulses answer the store strobe one cycle later
`timescale 1ns/1ps
`default_nettype none
module fspc_monitor #(
    parameter PAGE_BITS = 7,
    parameter [15:0] BOOT_VECTOR = 16'h1C00
) (
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic [3:0]           reg_addr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata,
    input wire logic                 boot_vector_fuse,
    input wire logic                 global_irq_en,
    input wire logic                 store_program_instr,
    input wire logic                 load_program_instr,
    input wire logic [15:0]          pointer,
    input wire logic [15:0]          data_regs,
    input wire logic [15:0]          reset_vector,
    input wire logic                 irq_req,
    input wire logic                 load_valid,
    input wire logic                 erase_start,
    input wire logic                 write_start,
    input wire logic [PAGE_BITS-1:0] op_page,
    input wire logic                 lock_prog,
    input wire logic [7:0]           lock_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_erase_page: assert property (erase_start |-> $past(store_program_instr)
        && op_page == $past(pointer[PAGE_BITS+6:7])) else $error("erase page wrong");
    a_write_store: assert property (write_start |-> $past(store_program_instr))
        else $error("write without store");
    a_lock_low: assert property (lock_prog |-> $past(store_program_instr)
        && lock_data == $past(data_regs[7:0])) else $error("lock value wrong");
    a_load_answer: assert property (load_valid |-> $past(load_program_instr))
        else $error("load answer without load");
    a_single_pulse: assert property (erase_start || write_start
        |=> !erase_start && !write_start) else $error("start pulse too long");
    a_boot_vector: assert property (!$past(sys_rst) && $stable(boot_vector_fuse)
        |-> reset_vector == (boot_vector_fuse ? 16'h0000 : BOOT_VECTOR))
        else $error("reset vector wrong");
    a_irq_gated: assert property (!global_irq_en && !$past(global_irq_en) |-> !irq_req)
        else $error("irq without global enable");
    a_reserved_zero: assert property ($past(reg_rd && reg_addr == 4'h0)
        |-> !reg_rdata[5]) else $error("reserved bit set");
endmodule
bind flash_self_program_control fspc_monitor #(
    .PAGE_BITS(PAGE_BITS), .BOOT_VECTOR(BOOT_VECTOR)) u_monitor (
    .clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .boot_vector_fuse,
    .global_irq_en, .store_program_instr, .load_program_instr, .pointer,
    .data_regs, .reset_vector, .irq_req, .load_valid, .erase_start,
    .write_start, .op_page, .lock_prog, .lock_data);
`default_nettype wire

// File: dv/tb.sv
// Purpose: directed bench for flash_self_program_control
// Assumes: partner ends each operation 20 cycles after start
// Notes:   pages below 0x70 lie in the concurrent section
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam [15:0] BOOT_VEC = 16'h1C00;
    logic        clk, sys_rst, reg_wr, reg_rd, fuse, gie, st, ld, done;
    logic        irq, stall, blocked, lvalid, es, ws, lp, hit, stall_seen;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, ldata, lock_data, rd, last_load;
    logic [15:0] pointer, data_regs, rvec, wword;
    logic [6:0]  op_page;
    logic [5:0]  waddr;
    integer      err_count, checked, ne, nw, nl, xe, xw, xl, j;
    logic [7:0]  pat [8] = '{8'h81, 8'h83, 8'h85, 8'h89, 8'h87, 8'h8F, 8'h9F, 8'h82};
    flash_self_program_control #(.BOOT_VECTOR(BOOT_VEC)) DUT (
        .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .boot_vector_fuse(fuse), .global_irq_en(gie), .store_program_instr(st),
        .load_program_instr(ld), .pointer, .data_regs, .lock_bits_in(8'h3C),
        .fuse_bits_in(8'hC3), .flash_byte(8'h00), .flash_done(done),
        .reset_vector(rvec), .irq_req(irq), .stall_core(stall),
        .section_blocked(blocked), .load_data(ldata), .load_valid(lvalid),
        .erase_start(es), .write_start(ws), .op_page, .lock_prog(lp), .lock_data,
        .write_word(wword), .word_addr(waddr));
    flash_array_model PARTNER (.clk, .sys_rst, .erase_start(es), .write_start(ws),
        .flash_done(done));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        ne <= ne + es;
        nw <= nw + ws;
        nl <= nl + lp;
        if (lvalid)
            last_load <= ldata;
        if (stall)
            stall_seen <= 1'b1;
        if (waddr == 6'h05 && wword == 16'hA5C3)
            hit <= 1'b1;
    end
    task automatic check(input string name, input logic [15:0] seen, exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic strobe(input bit is_load, input int k);
        repeat (k - 1) @(posedge clk);
        if (is_load)
            ld <= 1'b1;
        else
            st <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        st <= 1'b0;
    endtask
    // Store strobe lands k cycles after the control write
    task automatic cmd(input logic [7:0] c, input logic [15:0] p, input int k);
        @(posedge clk);
        pointer <= p;
        reg_addr <= 4'h0;
        reg_wdata <= c;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (k > 0)
            strobe(1'b0, k);
    endtask
    task automatic reg_read(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    task automatic counts;
        @(posedge clk);
        #1 check("erase pulses", ne, xe);
        check("write pulses", nw, xw);
        check("lock pulses", nl, xl);
    endtask
    task automatic wait_idle;
        int i;
        rd = 8'h01;
        for (i = 0; i < 40 && rd[0] !== 1'b0; i = i + 1)
            reg_read(4'h0);
        check("store enable", rd[0], 1'b0);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #2000000;
        err_count = err_count + 1;
        final_report;
    end
    initial
    begin
        {reg_wr, reg_rd, st, ld, stall_seen, hit, reg_addr, reg_wdata} = '0;
        {pointer, last_load, ne, nw, nl, xe, xw, xl, err_count, checked} = '0;
        {fuse, gie, sys_rst, data_regs} = {3'b111, 16'hA5C3};
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        reg_read(4'h0);
        check("control reset", rd, 8'h00);
        reg_read(4'hF);
        check("unmapped read", rd, 8'h00);
        check("application vector", rvec, 16'h0000);
        @(posedge clk);
        {sys_rst, fuse} <= 2'b10;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("boot vector", rvec, BOOT_VEC);
        $display("reset test done");
        cmd(8'h81, 16'h018A, 1);
        // Re-enable left to expire, so only the abort can empty the buffer
        cmd(8'h91, 16'h0000, 5);
        cmd(8'h85, 16'h0180, 2);
        xw = xw + 1;
        counts;
        reg_read(4'h0);
        check("busy and enable", rd & 8'h61, 8'h41);
        check("section blocked", blocked, 1'b1);
        check("irq while busy", irq, 1'b0);
        cmd(8'h91, 16'h0000, 1);
        counts;
        check("blocked after refusal", blocked, 1'b1);
        wait_idle;
        check("discarded word", hit, 1'b0);
        check("no stall", stall_seen, 1'b0);
        check("irq when idle", irq, 1'b1);
        cmd(8'h81, 16'h018A, 4);
        reg_read(4'h0);
        check("busy after load", rd[6], 1'b0);
        cmd(8'h85, 16'h0180, 3);
        xw = xw + 1;
        wait_idle;
        check("buffer word written", hit, 1'b1);
        hit = 1'b0;
        cmd(8'h85, 16'h0180, 1);
        xw = xw + 1;
        wait_idle;
        check("buffer cleared", hit, 1'b0);
        cmd(8'h91, 16'h0000, 1);
        reg_read(4'h0);
        check("busy cleared", rd[6], 1'b0);
        check("section readable", blocked, 1'b0);
        $display("page test done");
        cmd(8'h83, 16'h3880, 4);
        pointer <= 16'h0000;
        xe = xe + 1;
        counts;
        check("latched page", op_page, 7'h71);
        wait_idle;
        check("core stalled", stall_seen, 1'b1);
        check("stalling erase", blocked, 1'b0);
        @(posedge clk);
        data_regs <= 16'hFF5A;
        cmd(8'h89, 16'hFFFF, 2);
        xl = xl + 1;
        counts;
        check("lock value", lock_data, 8'h5A);
        wait_idle;
        cmd(8'h89, 16'h0000, 0);
        strobe(1'b1, 3);
        counts;
        check("lock readback", last_load, 8'h3C);
        repeat (4) @(posedge clk);
        cmd(8'h89, 16'h0001, 0);
        strobe(1'b1, 1);
        counts;
        check("fuse readback", last_load, 8'hC3);
        $display("erase and lock test done");
        for (j = 0; j < 8; j = j + 1)
        begin
            cmd(pat[j], 16'h0180, (j < 4) ? 5 : 1);
            counts;
            reg_read(4'h0);
            check("command bits", rd & 8'h1F, 8'h00);
        end
        @(posedge clk);
        gie <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("irq masked", irq, 1'b0);
        $display("window test done");
        final_report;
    end
endmodule
`default_nettype wire
